// >>> phy_test_and_link_drop_cfg.sv
// Test pattern, crossover timer and quick link-drop register bank
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "phy_test_cfg_map.svh"

// Functional notes
// R1 - Pulse select sets amplitude/polarity, reset 01
// R2 - Fast pattern: one, then 1..31 zeros
// R3 - Bit 8 enables fast pattern if bit4 low
// R4 - Software clears test mode before rewriting
// R5 - Software forces 100 Mbps for fast pattern
// R6 - Channel select: bit7 all, else one
// R7 - Bit 4 enables 10 Mbps test modes
// R8 - Four-bit code picks 10 Mbps pattern
// R9 - Window count bits 13:9, reset 10 us
// R10 - Quick crossover timer bits 8:4, reset 1
// R11 - Slow crossover timer bits 3:0, reset F
// R12 - Bit 15 drops link without receive signal
// R13 - Bit 14 skips maximum wait period
// R14 - Status bits 12:8 latch, clear on read
// R15 - Bits 4:0 enable combinable drop criteria
// R16 - Bit 13 read-only slicer stuck status
module phy_test_and_link_drop_cfg
  import phy_test_cfg_pkg::*;
#(
  parameter int WIN_UNIT_CYCLES = `WIN_UNIT_CYC
) (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  // Register port
  input  wire logic [5:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  // Line status pins
  input  wire logic        RX_SIGNAL,
  input  wire logic [4:0]  DROP_EVENTS,
  input  wire logic        SLICER_STUCK,
  // Test stimulus
  output logic             TEST_ACTIVE_TEN,
  output logic             TEST_ACTIVE_FAST,
  output logic      [3:0]  TEN_PATTERN,
  output logic      [1:0]  PULSE_SHAPE,
  output logic      [3:0]  CHANNEL_ENABLE,
  output logic             FAST_PATTERN_BIT,
  // Crossover timers
  output logic      [4:0]  QUICK_CROSSOVER_TIMER,
  output logic      [3:0]  SLOW_CROSSOVER_TIMER,
  // Link drop
  output logic             LINK_DROP,
  output logic             TX_DISABLE,
  // Interrupt
  output logic             IRQ
);

  // ************************************************************
  // Pin synchronisers: three stages, second and third must agree
  // ************************************************************
  logic [6:0] sync1_q, sync2_q, sync3_q, pin_q;
  wire  [6:0] pin_raw = {SLICER_STUCK, RX_SIGNAL, DROP_EVENTS};
  wire  [6:0] pin_agree = ~(sync2_q ^ sync3_q);

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      sync3_q <= 7'h00;
      pin_q   <= 7'h00;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q   <= (pin_agree & sync3_q) | (~pin_agree & pin_q);
    end
  end

  wire [4:0] drop_ev   = pin_q[4:0];
  wire       rx_signal = pin_q[5];
  wire       stuck     = pin_q[6];

  // ************************************************************
  // Register file
  // ************************************************************
  logic [15:0] tpc_q, tmr_q, ldc_q;
  logic [4:0]  drop_stat_q;
  logic [2:0]  irq_stat_q, irq_en_q;

  function automatic logic sel(input logic [5:0] a, input logic [5:0] o);
    return a == o;
  endfunction

  wire wr_tpc = REG_WR && sel(REG_ADDR, `OFS_TEST_PATTERN_CONTROL);
  wire wr_tmr = REG_WR && sel(REG_ADDR, `OFS_CROSSOVER_AND_DROP_TIMERS);
  wire wr_ldc = REG_WR && sel(REG_ADDR, `OFS_LINK_DROP_CONFIG);
  wire rd_ldc = REG_RD && sel(REG_ADDR, `OFS_LINK_DROP_CONFIG);
  wire rd_ist = REG_RD && sel(REG_ADDR, `OFS_IRQ_STATUS);
  wire wr_ien = REG_WR && sel(REG_ADDR, `OFS_IRQ_ENABLE);
  wire wr_icl = REG_WR && sel(REG_ADDR, `OFS_IRQ_CLEAR);

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      tpc_q <= `RST_TEST_PATTERN_CONTROL; // [R1] [R6]
      tmr_q <= `RST_CROSSOVER_AND_DROP_TIMERS; // [R9] [R10] [R11]
      ldc_q <= `RST_LINK_DROP_CONFIG;
    end else begin
      if (wr_tpc) tpc_q <= REG_WDATA & `TPC_RW_MASK;
      if (wr_tmr) tmr_q <= REG_WDATA & `TMR_RW_MASK;
      // Status and stuck bits are not writable
      if (wr_ldc) ldc_q <= REG_WDATA & `LDC_RW_MASK; // [R16]
    end
  end

  // ************************************************************
  // Test mode decode
  // ************************************************************
  wire        ten_en   = tpc_q[`TPC_TEN_EN]; // [R7]
  wire        fast_en  = tpc_q[`TPC_EXT_EN] && !ten_en; // [R3]
  wire [4:0]  run_len  = {tpc_q[`TPC_LEN_MSB], tpc_q[3:0]}; // [R2]

  assign TEST_ACTIVE_TEN  = ten_en;
  assign TEST_ACTIVE_FAST = fast_en;
  assign TEN_PATTERN      = ten_pattern_t'(tpc_q[3:0]); // [R8]
  assign PULSE_SHAPE      = pulse_shape_t'(tpc_q[`TPC_PULSE_HI:`TPC_PULSE_LO]); // [R1]
  // One-hot channel A..D, or all four
  assign CHANNEL_ENABLE = tpc_q[`TPC_CH_ALL] ? 4'hF :
                          4'(4'h1 << tpc_q[`TPC_CH_HI:`TPC_CH_LO]); // [R6]

  // Shift register view: position 0 sends the one, then run_len zeros
  logic [4:0] pat_pos_q;
  always_ff @(posedge SYS_CLK) begin
    if (RESET || !fast_en || run_len == 5'h00) begin
      pat_pos_q <= 5'h00; // [R2]
    end else if (pat_pos_q >= run_len) begin
      pat_pos_q <= 5'h00;
    end else begin
      pat_pos_q <= pat_pos_q + 5'h01;
    end
  end

  // Empty length clears the pattern, output stays zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      FAST_PATTERN_BIT <= 1'b0;
    end else begin
      FAST_PATTERN_BIT <= fast_en && run_len != 5'h00
                          && pat_pos_q == 5'h00; // [R2]
    end
  end

  assign QUICK_CROSSOVER_TIMER = tmr_q[`TMR_FAST_HI:`TMR_FAST_LO]; // [R10]
  assign SLOW_CROSSOVER_TIMER  = tmr_q[`TMR_SLOW_HI:`TMR_SLOW_LO]; // [R11]

  // ************************************************************
  // Quick link-drop observation window
  // ************************************************************
  wire [4:0] win_units = tmr_q[`TMR_WIN_HI:`TMR_WIN_LO]; // [R9]
  wire [4:0] modes     = ldc_q[`LDC_MODES_HI:`LDC_MODES_LO];
  wire       skip_wait = ldc_q[`LDC_SKIP_WAIT];
  logic [15:0] unit_cnt_q;
  logic [4:0]  win_cnt_q;
  logic [4:0]  seen_q;
  logic        drop_q;
  wire         unit_tick = unit_cnt_q == 16'(WIN_UNIT_CYCLES - 1);
  wire         win_end   = unit_tick && win_cnt_q >= win_units;
  wire [4:0]   hit       = drop_ev & modes; // [R15]
  // Skipping the wait drops on the first qualifying event
  // Criteria disabled mid-window must not drop at its end
  wire         drop_now  = skip_wait ? |hit
                                     : (win_end && |(seen_q & modes)); // [R13]

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      unit_cnt_q <= 16'h0000;
      win_cnt_q  <= 5'h00;
      seen_q     <= 5'h00;
    end else begin
      unit_cnt_q <= unit_tick ? 16'h0000 : unit_cnt_q + 16'h0001;
      if (win_end) begin
        win_cnt_q <= 5'h00;
        seen_q    <= 5'h00;
      end else begin
        if (unit_tick) win_cnt_q <= win_cnt_q + 5'h01;
        seen_q <= seen_q | hit;
      end
    end
  end

  // Link held down until the line returns with no enabled criterion hitting
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      drop_q <= 1'b0;
    end else if (drop_now) begin
      drop_q <= 1'b1;
    end else if (rx_signal && hit == 5'h00) begin
      drop_q <= 1'b0;
    end
  end

  wire force_drop = ldc_q[`LDC_DROP_EN] && !rx_signal; // [R12]
  assign LINK_DROP  = drop_q || force_drop; // [R12]
  assign TX_DISABLE = force_drop; // [R12]

  // Latched status; a new hit wins over read clear
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      drop_stat_q <= 5'h00;
    end else begin
      drop_stat_q <= (rd_ldc ? 5'h00 : drop_stat_q) | hit; // [R14]
    end
  end

  // ************************************************************
  // Interrupts: 0 drop status, 1 forced drop, 2 slicer stuck
  // ************************************************************
  logic       stuck_d1_q;
  logic       force_d1_q;
  wire  [2:0] irq_ev = {stuck && !stuck_d1_q, force_drop && !force_d1_q,
                        |hit};

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      irq_stat_q <= 3'h0;
      irq_en_q   <= 3'h0;
      stuck_d1_q <= 1'b0;
      force_d1_q <= 1'b0;
    end else begin
      stuck_d1_q <= stuck;
      force_d1_q <= force_drop;
      if (wr_ien) irq_en_q <= REG_WDATA[2:0];
      irq_stat_q <= (wr_icl ? irq_stat_q & ~REG_WDATA[2:0] : irq_stat_q)
                    | irq_ev;
    end
  end

  assign IRQ = |(irq_stat_q & irq_en_q);

  // ************************************************************
  // Read data, one cycle after the strobe
  // ************************************************************
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (REG_ADDR)
      `OFS_TEST_PATTERN_CONTROL:      rd_mux = tpc_q;
      `OFS_CROSSOVER_AND_DROP_TIMERS: rd_mux = tmr_q;
      `OFS_LINK_DROP_CONFIG: begin
        rd_mux = ldc_q;
        rd_mux[`LDC_STUCK] = stuck; // [R16]
        rd_mux[`LDC_STAT_HI:`LDC_STAT_LO] = drop_stat_q; // [R14]
      end
      `OFS_IRQ_STATUS: rd_mux = {13'h0000, irq_stat_q};
      `OFS_IRQ_ENABLE: rd_mux = {13'h0000, irq_en_q};
      default:         rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      REG_RDATA <= 16'h0000;
    end else begin
      REG_RDATA <= REG_RD ? rd_mux : 16'h0000;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence s_read_drop;
    rd_ldc ##1 1'b1;
  endsequence

  chk_pulse_reset_value: assert property ( // [R1]
    $rose(!RESET) |-> $past(RESET) && PULSE_SHAPE == 2'b01 || wr_tpc)
    else $error("pulse select reset wrong");
  chk_fast_needs_ten_off: assert property ( // [R3]
    TEST_ACTIVE_FAST |-> !TEST_ACTIVE_TEN && tpc_q[`TPC_EXT_EN])
    else $error("fast pattern active with ten mode");
  chk_zero_len_quiet: assert property ( // [R2]
    (fast_en && run_len == 5'h00) [*2] |-> !FAST_PATTERN_BIT)
    else $error("empty pattern still sending");
  chk_one_then_zeros: assert property ( // [R2]
    FAST_PATTERN_BIT && $stable(tpc_q) |=> !FAST_PATTERN_BIT)
    else $error("pattern one not followed by zero");
  chk_channel_all: assert property ( // [R6]
    tpc_q[`TPC_CH_ALL] |-> CHANNEL_ENABLE == 4'hF)
    else $error("all channel select ignored");
  chk_channel_one: assert property ( // [R6]
    !tpc_q[`TPC_CH_ALL] |-> $onehot(CHANNEL_ENABLE))
    else $error("single channel select wrong");
  chk_force_drop_tx: assert property ( // [R12]
    ldc_q[`LDC_DROP_EN] && !rx_signal |-> LINK_DROP && TX_DISABLE)
    else $error("no drop without receive signal");
  chk_skip_wait_drop: assert property ( // [R13]
    skip_wait && |hit |=> LINK_DROP)
    else $error("skip wait did not drop");
  chk_status_latch: assert property ( // [R14]
    |hit |=> (drop_stat_q & $past(hit)) == $past(hit))
    else $error("drop status not latched");
  chk_status_clear: assert property ( // [R14]
    s_read_drop |-> (drop_stat_q & ~$past(hit)) == 5'h00)
    else $error("drop status not cleared on read");
  chk_stuck_readonly: assert property ( // [R16]
    wr_ldc |=> ldc_q[`LDC_STUCK] == 1'b0)
    else $error("stuck bit took a write");
  chk_timer_fields: assert property ( // [R10]
    wr_tmr |=> QUICK_CROSSOVER_TIMER == $past(REG_WDATA[8:4]))
    else $error("quick crossover timer not stored");

  sequence s_window_close;
    !skip_wait && win_end && |(seen_q & modes);
  endsequence

  chk_slow_timer_stored: assert property ( // [R11]
    wr_tmr |=> SLOW_CROSSOVER_TIMER == $past(REG_WDATA[3:0]))
    else $error("slow crossover timer not stored");
  chk_window_stored: assert property ( // [R9]
    wr_tmr |=> win_units == $past(REG_WDATA[`TMR_WIN_HI:`TMR_WIN_LO]))
    else $error("drop window count not stored");
  chk_window_drop: assert property ( // [R9]
    s_window_close |=> LINK_DROP)
    else $error("no drop at window end");
  chk_no_early_drop: assert property ( // [R9]
    !skip_wait && !win_end && !drop_q |=> !drop_q)
    else $error("drop before window end");
  chk_disabled_criteria: assert property ( // [R15]
    modes == 5'h00 && !drop_q |=> !drop_q)
    else $error("drop with all criteria off");
  chk_pulse_stored: assert property ( // [R1]
    wr_tpc |=> PULSE_SHAPE == $past(REG_WDATA[11:10]))
    else $error("pulse select not stored");
  chk_ten_enable: assert property ( // [R7]
    wr_tpc |=> TEST_ACTIVE_TEN == $past(REG_WDATA[`TPC_TEN_EN]))
    else $error("ten mode enable not stored");
  chk_fast_enable: assert property ( // [R3]
    wr_tpc && !REG_WDATA[`TPC_TEN_EN] |=>
      TEST_ACTIVE_FAST == $past(REG_WDATA[`TPC_EXT_EN]))
    else $error("fast pattern enable not stored");
  chk_stuck_readback: assert property ( // [R16]
    rd_ldc |=> REG_RDATA[`LDC_STUCK] == $past(stuck))
    else $error("stuck bit read back wrong");
  chk_rdata_idle: assert property (
    !REG_RD |=> REG_RDATA == 16'h0000)
    else $error("read data not zero when idle");

endmodule // phy_test_and_link_drop_cfg

// >>> phy_test_cfg_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PHY_TEST_CFG_MAP_SVH
`define PHY_TEST_CFG_MAP_SVH

// ************************************************************
// Register offsets (management register index)
// ************************************************************
`define OFS_TEST_PATTERN_CONTROL      6'h25
`define OFS_CROSSOVER_AND_DROP_TIMERS 6'h2C
`define OFS_LINK_DROP_CONFIG          6'h2D
`define OFS_IRQ_STATUS                6'h3C
`define OFS_IRQ_ENABLE                6'h3D
`define OFS_IRQ_CLEAR                 6'h3E

// ************************************************************
// Reset values
// ************************************************************
`define RST_TEST_PATTERN_CONTROL      16'h0480
`define RST_CROSSOVER_AND_DROP_TIMERS 16'h141F
`define RST_LINK_DROP_CONFIG          16'h0000

// ************************************************************
// Field positions
// ************************************************************
`define TPC_PULSE_HI    11
`define TPC_PULSE_LO    10
`define TPC_LEN_MSB     9
`define TPC_EXT_EN      8
`define TPC_CH_ALL      7
`define TPC_CH_HI       6
`define TPC_CH_LO       5
`define TPC_TEN_EN      4
`define TPC_RW_MASK     16'h0FFF
`define TMR_WIN_HI      13
`define TMR_WIN_LO      9
`define TMR_FAST_HI     8
`define TMR_FAST_LO     4
`define TMR_SLOW_HI     3
`define TMR_SLOW_LO     0
`define TMR_RW_MASK     16'h3FFF
`define LDC_DROP_EN     15
`define LDC_SKIP_WAIT   14
`define LDC_STUCK       13
`define LDC_STAT_HI     12
`define LDC_STAT_LO     8
`define LDC_MODES_HI    4
`define LDC_MODES_LO    0
`define LDC_RW_MASK     16'hC01F

// ************************************************************
// Timing: one window unit is 1 us; counts at 40 MHz
// ************************************************************
`define CLK_PERIOD_PS   25000
`define WIN_UNIT_NS     1000
`define WIN_UNIT_CYC    ((`WIN_UNIT_NS * 1000) / `CLK_PERIOD_PS)

`endif

// >>> phy_test_cfg_pkg.sv
// Types shared by the test and link-drop configuration block
package phy_test_cfg_pkg;
  typedef enum logic [1:0] {
    PULSE_POS2,
    PULSE_NEG2,
    PULSE_POS1,
    PULSE_NEG1
  } pulse_shape_t;

  typedef enum logic [3:0] {
    PAT_LINK_PULSE, PAT_ONE_SINGLE, PAT_ZERO_SINGLE, PAT_ONE_REPEAT,
    PAT_ZERO_REPEAT, PAT_PREAMBLE, PAT_ONE_IDLE, PAT_ZERO_IDLE,
    PAT_1001_REPEAT, PAT_RANDOM, PAT_IDLE_00, PAT_IDLE_01,
    PAT_IDLE_10, PAT_IDLE_11, PAT_RSVD_E, PAT_RSVD_F
  } ten_pattern_t;

  typedef enum logic [1:0] {
    TEST_OFF,
    TEST_TEN,
    TEST_FAST
  } test_mode_t;
endpackage

// >>> line_partner_model.sv
// Far-end line model: receive signal, drop criteria and slicer state
`timescale 1ns/1ps

module line_partner_model (
  // Clock
  input  wire logic       clk,
  // Scenario controls
  input  wire logic       sig_on,
  input  wire logic [4:0] hits,
  input  wire logic       stuck,
  // Line status toward the device
  output logic            rx_signal = 1'b1,
  output logic [4:0]      drop_events = 5'h00,
  output logic            slicer_stuck = 1'b0
);
  // Cable events land after an edge, unrelated to register traffic
  always @(posedge clk) begin
    rx_signal    <= sig_on;
    drop_events  <= hits;
    slicer_stuck <= stuck;
  end
endmodule // line_partner_model

// >>> tb.sv
// Self-checking bench for the test and link-drop register bank
`timescale 1ns/1ps
`include "phy_test_cfg_map.svh"

module tb
  import phy_test_cfg_pkg::*;
;
  // ********************************************************
  // Signals
  // ********************************************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        sig_on = 1'b1;
  logic        stuck = 1'b0;
  logic [4:0]  hits = 5'h00;
  logic [15:0] rdata;
  logic        t_ten, t_fast, fast_bit, link_drop, tx_dis, irq;
  logic        rx_sig, stuck_pin;
  logic [4:0]  ev_pins, quick_t;
  logic [3:0]  ten_pat, ch_en, slow_t;
  logic [1:0]  pulse;
  int          num_errors = 0;
  int          tests_run = 0;
  int          lens [4] = '{3, 1, 31, 0};

  always #12.5 clk = ~clk;

  line_partner_model line (
    .clk(clk), .sig_on(sig_on), .hits(hits), .stuck(stuck),
    .rx_signal(rx_sig), .drop_events(ev_pins), .slicer_stuck(stuck_pin)
  );

  // Small window unit keeps the drop window short
  phy_test_and_link_drop_cfg #(.WIN_UNIT_CYCLES(4)) dut (
    .SYS_CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .RX_SIGNAL(rx_sig),
    .DROP_EVENTS(ev_pins), .SLICER_STUCK(stuck_pin),
    .TEST_ACTIVE_TEN(t_ten), .TEST_ACTIVE_FAST(t_fast),
    .TEN_PATTERN(ten_pat), .PULSE_SHAPE(pulse), .CHANNEL_ENABLE(ch_en),
    .FAST_PATTERN_BIT(fast_bit), .QUICK_CROSSOVER_TIMER(quick_t),
    .SLOW_CROSSOVER_TIMER(slow_t), .LINK_DROP(link_drop),
    .TX_DISABLE(tx_dis), .IRQ(irq)
  );

  // ********************************************************
  // Tasks
  // ********************************************************
  task automatic summarize();
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata, exp);
  endtask

  task automatic set_line(input logic [4:0] h, input logic s,
                          input logic st);
    @(posedge clk);
    hits <= h;
    sig_on <= s;
    stuck <= st;
  endtask

  task automatic wait_drop(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && link_drop !== v; n++) tick(1);
    if (n == lim) begin
      num_errors++;
      $display("CHECK FAILED %0t link drop wait ran out", $time);
      summarize();
    end
  endtask

  // Zero run between ones; a zero length must leave the line quiet
  task automatic chk_run(input int len);
    int n, z;
    for (n = 0; n < 64 && fast_bit !== 1'b1; n++) tick(1);
    if (len == 0) begin
      cmp(16'(n), 16'h0040);
    end else begin
      tick(1);
      for (z = 0; z < 64 && fast_bit === 1'b0; z++) tick(1);
      cmp(16'(z), 16'(len));
      cmp(16'(fast_bit), 16'h0001);
    end
  endtask

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    int i;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`OFS_TEST_PATTERN_CONTROL, 16'h0480);
    rd_chk(`OFS_CROSSOVER_AND_DROP_TIMERS, 16'h141F);
    rd_chk(`OFS_LINK_DROP_CONFIG, 16'h0000);
    cmp(16'({pulse, ch_en}), 16'h001F);
    cmp(16'({quick_t, slow_t}), 16'h001F);
    wr_reg(`OFS_TEST_PATTERN_CONTROL, 16'hFFFF);
    rd_chk(`OFS_TEST_PATTERN_CONTROL, 16'h0FFF);
    cmp(16'(t_fast), 16'h0000);
    wr_reg(`OFS_CROSSOVER_AND_DROP_TIMERS, 16'hEA5A);
    rd_chk(`OFS_CROSSOVER_AND_DROP_TIMERS, 16'h2A5A);
    cmp(16'({quick_t, slow_t}), 16'h005A);
    wr_reg(`OFS_LINK_DROP_CONFIG, 16'hFFFF);
    rd_chk(`OFS_LINK_DROP_CONFIG, 16'hC01F);
    wr_reg(6'h10, 16'hFFFF);
    rd_chk(6'h10, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wr_reg(`OFS_TEST_PATTERN_CONTROL, 16'h0000);
      wr_reg(`OFS_TEST_PATTERN_CONTROL, 16'((i << 10) | (i << 5)));
      tick(1);
      cmp(16'({pulse, ch_en}), 16'((i << 4) | (1 << i)));
    end
    for (i = 0; i < 14; i++) begin
      wr_reg(`OFS_TEST_PATTERN_CONTROL, 16'h0000);
      wr_reg(`OFS_TEST_PATTERN_CONTROL, 16'(16'h0110 | i));
      tick(1);
      cmp(16'({t_ten, t_fast, ten_pat}), 16'(6'h20 | i));
    end
    // Speed is taken as forced to 100 Mbps by the host
    foreach (lens[k]) begin
      wr_reg(`OFS_TEST_PATTERN_CONTROL, 16'h0000);
      wr_reg(`OFS_TEST_PATTERN_CONTROL,
             16'(16'h0100 | ((lens[k] & 16) << 5) | (lens[k] & 15)));
      tick(1);
      cmp(16'(t_fast), 16'h0001);
      chk_run(lens[k]);
    end
    // Back to the reset window so the drop lands inside the wait bound
    wr_reg(`OFS_CROSSOVER_AND_DROP_TIMERS, `RST_CROSSOVER_AND_DROP_TIMERS);
    wr_reg(`OFS_LINK_DROP_CONFIG, 16'h0000);
    wr_reg(`OFS_IRQ_ENABLE, 16'h0001);
    wr_reg(`OFS_LINK_DROP_CONFIG, 16'h0001);
    set_line(5'h01, 1'b1, 1'b0);
    tick(8);
    cmp(16'(irq), 16'h0001);
    wait_drop(1'b1, 80);
    set_line(5'h00, 1'b1, 1'b0);
    wait_drop(1'b0, 100);
    rd_chk(`OFS_LINK_DROP_CONFIG, 16'h0101);
    rd_chk(`OFS_LINK_DROP_CONFIG, 16'h0001);
    wr_reg(`OFS_IRQ_CLEAR, 16'h0001);
    tick(1);
    cmp(16'(irq), 16'h0000);
    wr_reg(`OFS_IRQ_ENABLE, 16'h0000);
    wr_reg(`OFS_LINK_DROP_CONFIG, 16'h4001);
    set_line(5'h1E, 1'b1, 1'b0);
    tick(8);
    cmp(16'(link_drop), 16'h0000);
    set_line(5'h01, 1'b1, 1'b0);
    wait_drop(1'b1, 10);
    cmp(16'(irq), 16'h0000);
    set_line(5'h00, 1'b1, 1'b1);
    wait_drop(1'b0, 100);
    rd_chk(`OFS_LINK_DROP_CONFIG, 16'h6101);
    wr_reg(`OFS_LINK_DROP_CONFIG, 16'h0000);
    rd_chk(`OFS_LINK_DROP_CONFIG, 16'h2000);
    rd_chk(`OFS_IRQ_STATUS, 16'h0005);
    wr_reg(`OFS_IRQ_CLEAR, 16'h0007);
    rd_chk(`OFS_IRQ_STATUS, 16'h0000);
    wr_reg(`OFS_IRQ_ENABLE, 16'h0002);
    wr_reg(`OFS_LINK_DROP_CONFIG, 16'h8000);
    set_line(5'h00, 1'b0, 1'b0);
    wait_drop(1'b1, 10);
    // Status bit lands one cycle after the drop shows
    tick(1);
    cmp(16'({tx_dis, irq}), 16'h0003);
    set_line(5'h00, 1'b1, 1'b0);
    wait_drop(1'b0, 20);
    cmp(16'(tx_dis), 16'h0000);
    summarize();
  end
endmodule // tb
